// file: src/tmr8_pkg.sv
// Package for the two-channel 8-bit compare timer.
// Assumes a 32-bit Avalon-MM slave with byte addressing of word registers.
package tmr8_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] TMR8_IDX_COUNT   = 8'hEA;
   localparam logic [7:0] TMR8_IDX_CTRL    = 8'hEB;
   localparam logic [7:0] TMR8_IDX_CH0CTL  = 8'hEC;
   localparam logic [7:0] TMR8_IDX_CH0CMP  = 8'hED;
   localparam logic [7:0] TMR8_IDX_CH1CTL  = 8'hEE;
   localparam logic [7:0] TMR8_IDX_CH1CMP  = 8'hEF;
   localparam logic [7:0] TMR8_IDX_FLAGS   = 8'hD8;
   localparam logic [7:0] TMR8_IDX_TICK    = 8'hF0;

   // Control fields
   localparam int TMR8_CTL_DIV_LSB   = 5;
   localparam int TMR8_CTL_START     = 4;
   localparam int TMR8_CTL_OVERFLOW_IRQ_MASK     = 3;
   localparam int TMR8_CTL_CLR       = 2;
   localparam int TMR8_CTL_MODE_LSB  = 0;
   // Channel control fields
   localparam int TMR8_CH_IM         = 6;
   localparam int TMR8_CH_ACT_LSB    = 3;
   localparam int TMR8_CH_EN         = 2;
   // Flag register fields
   localparam int TMR8_FLG_OVF       = 3;
   localparam int TMR8_FLG_CH0       = 4;
   localparam int TMR8_FLG_CH1       = 5;

   // Reset values
   localparam logic [7:0] TMR8_CTRL_RST  = 8'h08;
   localparam logic [7:0] TMR8_CHCTL_RST = 8'h40;
   localparam logic [7:0] TMR8_ZERO8     = 8'h00;
   localparam logic [7:0] TMR8_FULL8     = 8'hFF;
   localparam logic [7:0] TMR8_TICK_RST  = 8'h00;

   typedef enum logic [1:0] {
      TMR8_MODE_FREE,
      TMR8_MODE_DOWN,
      TMR8_MODE_MODULO,
      TMR8_MODE_UPDOWN
   } tmr8_mode_type;

   typedef enum logic [2:0] {
      TMR8_ACT_SET,
      TMR8_ACT_CLEAR,
      TMR8_ACT_TOGGLE,
      TMR8_ACT_SET_UP,
      TMR8_ACT_CLR_UP,
      TMR8_ACT_SET_ZERO,
      TMR8_ACT_CLR_ZERO,
      TMR8_ACT_NONE
   } tmr8_act_type;
endpackage : tmr8_pkg

// file: src/tmr8_timer.sv
// Two-channel 8-bit compare timer with prescaler and four counting modes.
// Assumes a single 50 MHz clock, synchronous srst, Avalon-MM slave.
//
// Notes on behaviour
// RQ1: Count register reads the live count; writes to it are ignored.
// RQ2: Prescaler bits 7:5 divide the tick by 1 up to 128 in powers of two.
// RQ3: Counter advances only while start bit 4 is set; otherwise holds.
// RQ4: Writing one to clear bit 2 zeroes the counter; bit reads zero.
// RQ5: Mode 00 counts 0x00 to 0xFF and wraps.
// RQ6: Mode 01 counts down from channel 0 compare value to 0x00.
// RQ7: Mode 10 counts 0x00 up to channel 0 compare value, restarts.
// RQ8: Mode 11 counts up to channel 0 compare value then down to zero.
// RQ9: Overflow mask ctrl bit 3, channel mask bit 6, all reset to one.
// RQ10: Channel control bit 2 enables compare actions for that channel.
// RQ11: On match: code 000 sets, 001 clears, 010 toggles the output.
// RQ12: Code 011 sets on up match, clears at zero or down match.
// RQ13: Code 100 clears on up match, sets at zero or down match.
// RQ14: Channel 0 codes 101/110 set/clear on match, opposite at 0x00.
// RQ15: Channel 1 codes 101/110 set/clear on match, opposite at ch0 value.
// RQ16: Software writes zeros to channel control reserved bits 1:0.
// RQ17: Each channel holds an 8-bit read/write compare value, reset zero.
// RQ18: Overflow sets flag bit 3 in flag register; writing zero clears.
// RQ19: Compare events set flag bits 4 and 5; writing zero clears.
// RQ20: Interrupt request rises only when a flag and its mask are both set.
// RQ21: Wrap from terminal count in any mode is the overflow event.
`timescale 1ns/1ps
module tmr8_timer
   import tmr8_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        system_tick,
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       channel_out,
   output logic             irq
);

   typedef struct packed {
      logic [1:0]  tick_sync;
      logic        tick_prev;
      logic [6:0]  prescale;
      logic [7:0]  count;
      logic        dir_down;
      logic [7:0]  ctrl;
      logic [7:0]  chctl0;
      logic [7:0]  chctl1;
      logic [7:0]  cmp0;
      logic [7:0]  cmp1;
      logic [2:0]  flags;
      logic [1:0]  outs;
      logic        ack;
      logic [31:0] rdata;
      logic        irq;
      logic        use_tick_pin;
   } tmr8_state_type;

   tmr8_state_type state_reg;
   tmr8_state_type state_next;

   ////////////////////////////////////////////////////////////////////////////
   // Combinational helpers
   logic          tick_edge;
   logic          step_en;
   logic [6:0]    div_mask;
   logic [7:0]    nxt_count;
   logic          nxt_down;
   logic          wrap_evt;
   logic          acc;
   logic          wr_hit;
   logic [7:0]    idx;
   logic [7:0]    wbyte;
   logic [1:0]    match;
   logic [7:0]    top;
   tmr8_mode_type mode;

   always_comb
   begin
      state_next = state_reg;
      idx        = avs_address[9:2];
      wbyte      = avs_writedata[7:0];
      acc        = (avs_read || avs_write) && !state_reg.ack;
      wr_hit     = acc && avs_write && avs_byteenable[0];
      mode       = tmr8_mode_type'(state_reg.ctrl[TMR8_CTL_MODE_LSB +: 2]);
      top        = state_reg.cmp0;

      // Tick source: synchronised pin edge, or every clock if selected off
      state_next.tick_sync = {state_reg.tick_sync[0], system_tick};
      state_next.tick_prev = state_reg.tick_sync[1];
      tick_edge = state_reg.use_tick_pin ? (state_reg.tick_sync[1] && !state_reg.tick_prev)
                                         : 1'b1;

      // Prescaler: step when low DIV bits of free counter are all ones [RQ2]
      div_mask = 7'((8'h01 << state_reg.ctrl[TMR8_CTL_DIV_LSB +: 3]) - 8'h01);
      step_en  = 1'b0;
      if (tick_edge)
      begin
         state_next.prescale = state_reg.prescale + 7'h01;
         step_en = ((state_reg.prescale & div_mask) == div_mask)
                   && state_reg.ctrl[TMR8_CTL_START];  // [RQ3]
      end

      // Counting modes
      nxt_count = state_reg.count;
      nxt_down  = state_reg.dir_down;
      wrap_evt  = 1'b0;
      case (mode)
         TMR8_MODE_FREE:
         begin
            nxt_count = state_reg.count + 8'h01;  // [RQ5]
            wrap_evt  = (state_reg.count == TMR8_FULL8);  // [RQ21]
         end
         TMR8_MODE_DOWN:
         begin
            if (state_reg.count == TMR8_ZERO8)  // [RQ6]
            begin
               nxt_count = top;
               wrap_evt  = 1'b1;  // [RQ21]
            end
            else
               nxt_count = state_reg.count - 8'h01;
         end
         TMR8_MODE_MODULO:
         begin
            if (state_reg.count >= top)  // [RQ7]
            begin
               nxt_count = TMR8_ZERO8;
               wrap_evt  = 1'b1;  // [RQ21]
            end
            else
               nxt_count = state_reg.count + 8'h01;
         end
         default:
         begin
            if (!state_reg.dir_down)  // [RQ8]
            begin
               if (state_reg.count >= top)
               begin
                  nxt_down  = (top != TMR8_ZERO8);
                  nxt_count = (top != TMR8_ZERO8) ? state_reg.count - 8'h01 : TMR8_ZERO8;
               end
               else
                  nxt_count = state_reg.count + 8'h01;
            end
            else if (state_reg.count == TMR8_ZERO8)
            begin
               nxt_down  = 1'b0;
               nxt_count = 8'h01;
               wrap_evt  = 1'b1;  // [RQ21]
            end
            else
               nxt_count = state_reg.count - 8'h01;
         end
      endcase

      // Compare actions, evaluated on the next count, in the same step that loads it
      for (int c = 0; c < 2; c++)
      begin
         logic [7:0]   cc;
         logic [7:0]   cv;
         tmr8_act_type act;
         logic         at_zero;
         logic         at_other;
         logic         up;
         logic         o;
         cc       = (c == 0) ? state_reg.chctl0 : state_reg.chctl1;
         cv       = (c == 0) ? state_reg.cmp0 : state_reg.cmp1;
         act      = tmr8_act_type'(cc[TMR8_CH_ACT_LSB +: 3]);
         up       = !nxt_down && (mode != TMR8_MODE_DOWN);
         at_zero  = (nxt_count == TMR8_ZERO8);
         at_other = (c == 0) ? at_zero : (nxt_count == state_reg.cmp0);  // [RQ14] [RQ15]
         match[c] = step_en && cc[TMR8_CH_EN] && (nxt_count == cv);  // [RQ10]
         o        = state_reg.outs[c];
         if (step_en && cc[TMR8_CH_EN])
         begin
            case (act)
               TMR8_ACT_SET:    if (match[c]) o = 1'b1;  // [RQ11]
               TMR8_ACT_CLEAR:  if (match[c]) o = 1'b0;  // [RQ11]
               TMR8_ACT_TOGGLE: if (match[c]) o = !o;    // [RQ11]
               TMR8_ACT_SET_UP:  // [RQ12]
               begin
                  if (match[c] && up) o = 1'b1;
                  else if (mode == TMR8_MODE_UPDOWN ? (match[c] && !up) : at_zero) o = 1'b0;
               end
               TMR8_ACT_CLR_UP:  // [RQ13]
               begin
                  if (match[c] && up) o = 1'b0;
                  else if (mode == TMR8_MODE_UPDOWN ? (match[c] && !up) : at_zero) o = 1'b1;
               end
               TMR8_ACT_SET_ZERO:
               begin
                  if (match[c]) o = 1'b1;
                  else if (at_other) o = 1'b0;
               end
               TMR8_ACT_CLR_ZERO:
               begin
                  if (match[c]) o = 1'b0;
                  else if (at_other) o = 1'b1;
               end
               default: o = state_reg.outs[c];
            endcase
         end
         state_next.outs[c] = o;
      end

      if (step_en)
      begin
         state_next.count    = nxt_count;
         state_next.dir_down = nxt_down;
      end

      ////////////////////////////////////////////////////////////////////////
      // Register writes; counter clear and flag clear by bus
      if (wr_hit)
      begin
         if (idx == TMR8_IDX_CTRL)
         begin
            state_next.ctrl = {wbyte[7:3], 1'b0, wbyte[1:0]};
            if (wbyte[TMR8_CTL_CLR])
            begin
               state_next.count    = TMR8_ZERO8;  // [RQ4]
               state_next.dir_down = 1'b0;
            end
         end
         else if (idx == TMR8_IDX_CH0CTL)
            state_next.chctl0 = {1'b0, wbyte[6:0]};  // [RQ16]
         else if (idx == TMR8_IDX_CH0CMP)
            state_next.cmp0 = wbyte;  // [RQ17]
         else if (idx == TMR8_IDX_CH1CTL)
            state_next.chctl1 = {1'b0, wbyte[6:0]};
         else if (idx == TMR8_IDX_CH1CMP)
            state_next.cmp1 = wbyte;  // [RQ17]
         else if (idx == TMR8_IDX_FLAGS)
            state_next.flags = state_reg.flags & wbyte[TMR8_FLG_OVF +: 3];
         else if (idx == TMR8_IDX_TICK)
            state_next.use_tick_pin = wbyte[0];
      end

      // Hardware set wins over a software clear
      state_next.flags = state_next.flags | {match[1], match[0], step_en && wrap_evt};  // [RQ18] [RQ19]

      // Interrupt request from masked flags
      state_next.irq = (state_reg.flags[0] && state_reg.ctrl[TMR8_CTL_OVERFLOW_IRQ_MASK])
                    || (state_reg.flags[1] && state_reg.chctl0[TMR8_CH_IM])
                    || (state_reg.flags[2] && state_reg.chctl1[TMR8_CH_IM]);  // [RQ20]

      // Read data; unmapped addresses return zero
      state_next.ack   = acc;
      state_next.rdata = 32'h0000_0000;
      if (acc && avs_read)
      begin
         if (idx == TMR8_IDX_COUNT)
            state_next.rdata[7:0] = state_reg.count;  // [RQ1]
         else if (idx == TMR8_IDX_CTRL)
            state_next.rdata[7:0] = state_reg.ctrl;   // [RQ4]
         else if (idx == TMR8_IDX_CH0CTL)
            state_next.rdata[7:0] = state_reg.chctl0;
         else if (idx == TMR8_IDX_CH0CMP)
            state_next.rdata[7:0] = state_reg.cmp0;
         else if (idx == TMR8_IDX_CH1CTL)
            state_next.rdata[7:0] = state_reg.chctl1;
         else if (idx == TMR8_IDX_CH1CMP)
            state_next.rdata[7:0] = state_reg.cmp1;
         else if (idx == TMR8_IDX_FLAGS)
            state_next.rdata[7:0] = {2'b00, state_reg.flags, 3'b000};
         else if (idx == TMR8_IDX_TICK)
            state_next.rdata[7:0] = {7'h00, state_reg.use_tick_pin};
      end

      if (srst)
      begin
         state_next              = '0;
         state_next.ctrl         = TMR8_CTRL_RST;   // [RQ9]
         state_next.chctl0       = TMR8_CHCTL_RST;  // [RQ9]
         state_next.chctl1       = TMR8_CHCTL_RST;
         state_next.use_tick_pin = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      state_reg <= state_next;
   end

   assign avs_readdata    = state_reg.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
   assign channel_out     = state_reg.outs;
   assign irq             = state_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_count_hold: assert property (@(posedge clock) disable iff (srst)  // [RQ3]
      !state_reg.ctrl[TMR8_CTL_START] && !wr_hit |=> $stable(state_reg.count))
      else $error("count moved while stopped");
   a_clear_zero: assert property (@(posedge clock) disable iff (srst)  // [RQ4]
      wr_hit && idx == TMR8_IDX_CTRL && wbyte[TMR8_CTL_CLR] |=> state_reg.count == 8'h00)
      else $error("clear did not zero counter");
   a_clr_reads_zero: assert property (@(posedge clock) disable iff (srst)  // [RQ4]
      !state_reg.ctrl[TMR8_CTL_CLR])
      else $error("clear bit stored");
   a_free_wrap: assert property (@(posedge clock) disable iff (srst)  // [RQ5]
      step_en && !wr_hit && mode == TMR8_MODE_FREE && state_reg.count == 8'hFF
      |=> state_reg.count == 8'h00 && state_reg.flags[0])
      else $error("free running wrap wrong");
   a_modulo_top: assert property (@(posedge clock) disable iff (srst)  // [RQ7]
      step_en && !wr_hit && mode == TMR8_MODE_MODULO && state_reg.count == state_reg.cmp0
      |=> state_reg.count == 8'h00)
      else $error("modulo did not restart");
   a_down_reload: assert property (@(posedge clock) disable iff (srst)  // [RQ6]
      step_en && !wr_hit && mode == TMR8_MODE_DOWN && state_reg.count == 8'h00
      |=> state_reg.count == $past(state_reg.cmp0))
      else $error("down mode reload wrong");
   a_match_flag: assert property (@(posedge clock) disable iff (srst)  // [RQ19]
      match[0] |=> state_reg.flags[1])
      else $error("channel 0 flag not set");
   a_irq_gate: assert property (@(posedge clock) disable iff (srst)  // [RQ20]
      state_reg.flags == 3'b000 |=> !irq)
      else $error("irq without pending flag");
   a_set_output: assert property (@(posedge clock) disable iff (srst)  // [RQ11]
      match[1] && state_reg.chctl1[5:3] == 3'b000 |=> channel_out[1])
      else $error("set action failed");
   a_bus_answer: assert property (@(posedge clock) disable iff (srst)
      avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");

   c_overflow: cover property (@(posedge clock) step_en && wrap_evt);
   c_updown_turn: cover property (@(posedge clock)
      step_en && mode == TMR8_MODE_UPDOWN && nxt_down && !state_reg.dir_down);
   c_pwm_ch1: cover property (@(posedge clock) match[1] && state_reg.chctl1[5:3] == 3'b101);
   c_irq: cover property (@(posedge clock) irq);
endmodule : tmr8_timer

// file: verif/tmr8_tb.sv
// Self-checking bench for the two-channel 8-bit compare timer.
// Assumes the tmr8_timer top and tmr8_pkg; assertions live in the design.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb
   import tmr8_pkg::*;
;
   logic        clock;
   logic        srst;
   logic        system_tick;
   logic [9:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  channel_out;
   logic        irq;
   int          fails;
   int          checked;
   logic [7:0]  q;
   logic [7:0]  c0;
   logic [7:0]  c1;
   logic [2:0]  acts [3];
   logic [1:0]  outs [3];
   logic        ens  [3];

   tmr8_timer uut (.clock(clock), .srst(srst), .system_tick(system_tick),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .channel_out(channel_out), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks and expectations
   task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] rd_q);
      int   n;
      logic w;
      n = 0;
      w = 1'b1;
      avs_address <= {idx, 2'b00};
      avs_read <= !wr_en;
      avs_write <= wr_en;
      avs_writedata <= {24'h000000, d};
      do
      begin
         @(posedge clock);
         w = avs_waitrequest;
         rd_q = avs_readdata[7:0];
         n++;
      end
      while (w !== 1'b0 && n < 50);
      `CHK("waitrequest", 1'b0, w)
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] dummy;
      bus(1'b1, idx, d, dummy);
   endtask : wr

   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00, q);
      `CHK(nm, e, q)
   endtask : rdchk

   function automatic logic [7:0] ctl(input logic [2:0] dv, input logic st,
                                      input logic ovm, input logic cl, input logic [1:0] md);
      return {dv, st, ovm, cl, md};
   endfunction : ctl

   function automatic logic [7:0] chctl(input logic im, input logic [2:0] act, input logic en);
      return {1'b0, im, act, en, 2'b00};
   endfunction : chctl

   // PWM levels for codes 101/110 with the count frozen at cnt
   function automatic logic [1:0] pwm(input logic inv, input logic [7:0] cnt);
      logic o0;
      logic o1;
      o0 = (cnt == c0);
      o1 = (cnt >= c1) && (cnt < c0);
      return inv ? {!o1, !o0} : {o1, o0};
   endfunction : pwm

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial
   begin
      clock = 1'b0;
      forever #10 clock = !clock;
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      fails++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tests
   initial
   begin
      fails = 0;
      checked = 0;
      srst = 1'b1;
      system_tick = 1'b0;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      void'($urandom(58));
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rdchk("ctrl reset", TMR8_IDX_CTRL, 8'h08);
      rdchk("ch0ctl reset", TMR8_IDX_CH0CTL, 8'h40);
      rdchk("ch1ctl reset", TMR8_IDX_CH1CTL, 8'h40);
      rdchk("ch0cmp reset", TMR8_IDX_CH0CMP, 8'h00);
      rdchk("count reset", TMR8_IDX_COUNT, 8'h00);
      rdchk("unmapped", 8'h10, 8'h00);
      `CHK("irq idle", 1'b0, irq)
      c0 = 8'($urandom());
      wr(TMR8_IDX_CH0CMP, c0);
      rdchk("ch0cmp rw", TMR8_IDX_CH0CMP, c0);
      wr(TMR8_IDX_COUNT, 8'h55);
      rdchk("count ro", TMR8_IDX_COUNT, 8'h00);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b0, 2'b00));
      repeat (20) @(posedge clock);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b0, 1'b1, 1'b0, 2'b00));
      bus(1'b0, TMR8_IDX_COUNT, 8'h00, c1);
      repeat (30) @(posedge clock);
      rdchk("count held", TMR8_IDX_COUNT, c1);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b0, 1'b1, 1'b1, 2'b00));
      rdchk("clear reads zero", TMR8_IDX_CTRL, 8'h08);
      rdchk("count cleared", TMR8_IDX_COUNT, 8'h00);
      $display("test registers done");
      for (int d = 0; d < 8; d++)
      begin
         wr(TMR8_IDX_CTRL, ctl(3'(d), 1'b1, 1'b1, 1'b1, 2'b00));
         repeat (16 << d) @(posedge clock);
         wr(TMR8_IDX_CTRL, ctl(3'(d), 1'b0, 1'b1, 1'b0, 2'b00));
         bus(1'b0, TMR8_IDX_COUNT, 8'h00, q);
         `CHK("prescale window", 1'b1, (q >= 8'd15) && (q <= 8'd21))
      end
      $display("test prescaler done");
      for (int m = 0; m < 4; m++)
      begin
         c0 = 8'd8 + 8'($urandom_range(32));
         wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b0, 1'b1, 1'b0, 2'b00));
         wr(TMR8_IDX_CH0CMP, c0);
         wr(TMR8_IDX_FLAGS, 8'h00);
         wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b1, 2'(m)));
         for (int k = 0; k < 20 && m != 0; k++)
         begin
            bus(1'b0, TMR8_IDX_COUNT, 8'h00, q);
            `CHK("count bound", 1'b1, q <= c0)
         end
         repeat (600) @(posedge clock);
         rdchk("overflow flag", TMR8_IDX_FLAGS, 8'h08);
         `CHK("irq ovf", 1'b1, irq)
      end
      wr(TMR8_IDX_FLAGS, 8'h00);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b0, 1'b1, 1'b0, 2'b00));
      rdchk("flag cleared", TMR8_IDX_FLAGS, 8'h00);
      $display("test modes done");
      c0 = 8'd12 + 8'($urandom_range(28));
      c1 = 8'd1 + 8'($urandom_range(10));
      wr(TMR8_IDX_CH0CMP, c0);
      wr(TMR8_IDX_CH1CMP, c1);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b1, 2'b10));
      acts = '{3'b000, 3'b001, 3'b001};
      ens  = '{1'b1, 1'b0, 1'b1};
      outs = '{2'b11, 2'b11, 2'b00};
      for (int r = 0; r < 3; r++)
      begin
         wr(TMR8_IDX_CH0CTL, chctl(1'b1, acts[r], ens[r]));
         wr(TMR8_IDX_CH1CTL, chctl(1'b1, acts[r], ens[r]));
         repeat (60) @(posedge clock);
         `CHK("set clear out", outs[r], channel_out)
      end
      for (int a = 0; a < 2; a++)
      begin
         wr(TMR8_IDX_CH0CTL, chctl(1'b1, 3'b101 + 3'(a), 1'b1));
         wr(TMR8_IDX_CH1CTL, chctl(1'b1, 3'b101 + 3'(a), 1'b1));
         for (int k = 0; k < 4; k++)
         begin
            wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b1, 2'b10));
            repeat ($urandom_range(160, 60)) @(posedge clock);
            wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b0, 1'b1, 1'b0, 2'b10));
            bus(1'b0, TMR8_IDX_COUNT, 8'h00, q);
            `CHK("pwm out", pwm(a[0], q), channel_out)
         end
      end
      wr(TMR8_IDX_CH0CTL, chctl(1'b1, 3'b011, 1'b1));
      wr(TMR8_IDX_CH1CTL, chctl(1'b1, 3'b100, 1'b1));
      for (int k = 0; k < 4; k++)
      begin
         wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b1, 2'b10));
         repeat ($urandom_range(160, 60)) @(posedge clock);
         wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b0, 1'b1, 1'b0, 2'b10));
         bus(1'b0, TMR8_IDX_COUNT, 8'h00, q);
         `CHK("up zero out", {q < c1, q == c0}, channel_out)
      end
      $display("test outputs done");
      wr(TMR8_IDX_FLAGS, 8'h00);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b0, 2'b10));
      repeat (60) @(posedge clock);
      rdchk("compare flags", TMR8_IDX_FLAGS, 8'h38);
      `CHK("irq set", 1'b1, irq)
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b0, 1'b0, 2'b10));
      wr(TMR8_IDX_CH0CTL, chctl(1'b0, 3'b110, 1'b1));
      wr(TMR8_IDX_CH1CTL, chctl(1'b0, 3'b110, 1'b1));
      repeat (4) @(posedge clock);
      `CHK("irq masked", 1'b0, irq)
      wr(TMR8_IDX_CH0CTL, chctl(1'b1, 3'b000, 1'b0));
      wr(TMR8_IDX_CH1CTL, chctl(1'b1, 3'b000, 1'b0));
      wr(TMR8_IDX_FLAGS, 8'h00);
      repeat (60) @(posedge clock);
      rdchk("disabled flags", TMR8_IDX_FLAGS, 8'h08);
      $display("test flags done");
      wr(TMR8_IDX_TICK, 8'h01);
      wr(TMR8_IDX_CTRL, ctl(3'b000, 1'b1, 1'b1, 1'b1, 2'b00));
      repeat (30) @(posedge clock);
      rdchk("tick idle", TMR8_IDX_COUNT, 8'h00);
      c1 = 8'($urandom_range(20, 5));
      for (int k = 0; k < int'(c1); k++)
      begin
         system_tick <= 1'b1;
         repeat (2) @(posedge clock);
         system_tick <= 1'b0;
         repeat (2) @(posedge clock);
      end
      repeat (5) @(posedge clock);
      rdchk("tick count", TMR8_IDX_COUNT, c1);
      $display("test tick pin done");
      stop_test();
   end
endmodule : tb
